//--- logic/dpmfi_mailbox.sv
/*
  two-sided 32-bit mailbox pair with byte full flags and interrupts.
  assumes both register ports run on clk; index 0 is host, 1 is local.
*/
`default_nettype none
module dpmfi_mailbox import dpmfi_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire dpmfi_req_t [1:0] req,
  input wire logic [1:0] req_valid,
  output logic [1:0] req_ready,
  output logic [1:0] rsp_valid,
  input wire logic [1:0] rsp_ready,
  output logic [1:0][DW-1:0] rsp_data,
  output logic [1:0] irq_n
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [1:0][DW-1:0] mbox;
    logic [1:0][3:0] full;
    logic [1:0][15:0] ctl;
  } dpmfi_core_t;
  dpmfi_core_t st_reg;
  dpmfi_core_t st_next;

  logic [1:0] acc;
  logic [1:0][DW-1:0] rdata;
  logic [1:0][3:0] set_m;
  logic [1:0][3:0] rd_clr;
  logic [1:0][3:0] rd_ev;
  logic [1:0] clr_in;
  logic [1:0] clr_out;
  logic [1:0] pend_in;
  logic [1:0] pend_out;
  logic [1:0][DW-1:0] ctl_word;
  logic [1:0] pend_hi;
  logic [1:0] pend_lo;
  logic freset;
  logic [DW-1:0] flags_word;

  assign acc = req_valid & req_ready;

  // ****************************************
  // status word, identical layout on both sides
  // ****************************************
  always_comb begin
    flags_word = '0;
    flags_word[FLAGS_L2H_LSB +: 4] = st_reg.full[SIDE_LOCAL];
    flags_word[FLAGS_H2L_LSB +: 4] = st_reg.full[SIDE_HOST];
  end

  // ****************************************
  // per-side interrupt units and answer buffers
  // ****************************************
  for (genvar s = 0; s < 2; s++) begin : g_side
    dpmfi_cond_t in_cond;
    dpmfi_cond_t out_cond;
    dpmfi_cond_t cond_a;
    dpmfi_cond_t cond_b;
    // one register carries both conditions
    assign cond_a = '{en: st_reg.ctl[s][CTL_EN_A],
                      sel: st_reg.ctl[s][CTL_SEL_A_LSB +: 2]};
    assign cond_b = '{en: st_reg.ctl[s][CTL_EN_B],
                      sel: st_reg.ctl[s][CTL_SEL_B_LSB +: 2]};
    assign out_cond = (s == SIDE_HOST) ? cond_a : cond_b;
    assign in_cond = (s == SIDE_HOST) ? cond_b : cond_a;
    // host reports incoming high, local reports outgoing high
    assign pend_hi[s] = (s == SIDE_HOST) ? pend_in[s] : pend_out[s];
    assign pend_lo[s] = (s == SIDE_HOST) ? pend_out[s] : pend_in[s];
    always_comb begin
      ctl_word[s] = '0;
      ctl_word[s][15:0] = st_reg.ctl[s];
      ctl_word[s][CTL_PEND_HI] = pend_hi[s];
      ctl_word[s][CTL_PEND_LO] = pend_lo[s];
      ctl_word[s][CTL_IRQ_BIT] = !irq_n[s];
    end

    dpmfi_irq u_irq (
      .clk(clk),
      .rstn(rstn),
      .in_cond(in_cond),
      .out_cond(out_cond),
      .in_wr_ev(set_m[1-s]),
      .out_rd_ev(rd_ev[s]),
      .in_full(st_reg.full[1-s]),
      .clr_in(clr_in[s]),
      .clr_out(clr_out[s]),
      .pend_in(pend_in[s]),
      .pend_out(pend_out[s]),
      .irq_n(irq_n[s])
    );

    dpmfi_fifo #(
      .WIDTH(DW),
      .DEPTH(BUF_DEPTH)
    ) u_buf (
      .clk(clk),
      .rstn(rstn),
      .in_valid(acc[s] && req[s].rd),
      .in_ready(req_ready[s]),
      .in_data(rdata[s]),
      .out_valid(rsp_valid[s]),
      .out_ready(rsp_ready[s]),
      .out_data(rsp_data[s])
    );
  end

  // ****************************************
  // register accesses and flag update
  // ****************************************
  always_comb begin
    st_next = st_reg;
    rdata = '0;
    set_m = '0;
    rd_clr = '0;
    rd_ev = '0;
    clr_in = '0;
    clr_out = '0;
    freset = 1'b0;
    for (int s = 0; s < 2; s++) begin
      if (acc[s] && req[s].rd) begin
        case (req[s].addr)
          ADDR_FLAGS: begin
            rdata[s] = flags_word;
          end
          ADDR_INBOUND: begin
            rdata[s] = st_reg.mbox[1-s];
            rd_clr[1-s] = req[s].be & st_reg.full[1-s];
          end
          ADDR_OUTBOUND: begin
            rdata[s] = st_reg.mbox[s];
          end
          ADDR_IRQ_CTRL: begin
            rdata[s] = ctl_word[s];
          end
          default: begin
            rdata[s] = '0;
          end
        endcase
      end
      if (acc[s] && req[s].wr) begin
        case (req[s].addr)
          ADDR_OUTBOUND: begin
            for (int b = 0; b < 4; b++) begin
              if (req[s].be[b]) begin
                st_next.mbox[s][8*b +: 8] = req[s].wdata[8*b +: 8];
              end
            end
            set_m[s] = req[s].be;
          end
          ADDR_IRQ_CTRL: begin
            for (int b = 0; b < 2; b++) begin
              if (req[s].be[b]) begin
                st_next.ctl[s][8*b +: 8] = req[s].wdata[8*b +: 8] & CTL_WMASK[8*b +: 8];
              end
            end
            if (req[s].be[2]) begin
              if (s == SIDE_HOST) begin
                clr_in[s] = req[s].wdata[CTL_PEND_HI];
                clr_out[s] = req[s].wdata[CTL_PEND_LO];
              end else begin
                clr_out[s] = req[s].wdata[CTL_PEND_HI];
                clr_in[s] = req[s].wdata[CTL_PEND_LO];
              end
            end
          end
          ADDR_RESET_CTRL: begin
            if (req[s].be[3] && req[s].wdata[RST_FLAG_BIT]) begin
              freset = 1'b1;
            end
          end
          default: begin
            // status, incoming and unmapped words keep their content
            freset = freset;
          end
        endcase
      end
    end
    // a set in the same cycle as a clear wins
    for (int s = 0; s < 2; s++) begin
      st_next.full[s] = ((freset ? FLAGS_RST : st_reg.full[s]) & ~rd_clr[s]) | set_m[s];
      rd_ev[s] = rd_clr[s] & ~st_next.full[s];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '{mbox: {2{MBOX_RST}}, full: {2{FLAGS_RST}}, ctl: {2{CTL_RST}}};
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_flag_set_host: assert property (
    acc[0] && req[0].wr && req[0].addr == ADDR_OUTBOUND && req[0].be[0]
    |=> st_reg.full[0][0])
    else $error("outgoing write did not set flag");
  chk_flag_clear_read: assert property (
    acc[1] && req[1].rd && req[1].addr == ADDR_INBOUND && req[1].be[0]
    && !(acc[0] && req[0].wr && req[0].addr == ADDR_OUTBOUND && req[0].be[0])
    |=> !st_reg.full[0][0])
    else $error("incoming read did not clear flag");
  chk_status_readonly: assert property (
    acc[0] && req[0].wr && req[0].addr == ADDR_FLAGS && !req[0].rd && !acc[1]
    |=> $stable(st_reg.full))
    else $error("status write changed a flag");
  chk_flag_reset_all: assert property (
    freset && set_m == '0 |=> st_reg.full == '0)
    else $error("flag reset left a flag set");
  chk_overwrite_data: assert property (
    acc[1] && req[1].wr && req[1].addr == ADDR_OUTBOUND && req[1].be[3]
    |=> st_reg.mbox[1][31:24] == $past(req[1].wdata[31:24]))
    else $error("outgoing write not stored");
  chk_host_irq_rise: assert property (
    st_reg.ctl[0][CTL_EN_B] && set_m[1][st_reg.ctl[0][CTL_SEL_B_LSB +: 2]]
    |=> !irq_n[0])
    else $error("host interrupt late after local write");
  chk_local_irq_rise: assert property (
    st_reg.ctl[1][CTL_EN_B] && rd_ev[1][st_reg.ctl[1][CTL_SEL_B_LSB +: 2]]
    |=> !irq_n[1] ##1 (!irq_n[1] || $past(clr_out[1])))
    else $error("local interrupt late after host read");
  chk_read_answer: assert property (
    acc[0] && req[0].rd && !rsp_valid[0] |=> rsp_valid[0])
    else $error("read answer missing");

  cov_host_to_local: cover property (
    acc[0] && req[0].wr && req[0].addr == ADDR_OUTBOUND
    ##[1:20] acc[1] && req[1].rd && req[1].addr == ADDR_INBOUND);
  cov_host_irq: cover property (irq_n[0] ##1 !irq_n[0] ##[1:20] irq_n[0]);
  cov_buffer_stall: cover property (req_valid[1] && !req_ready[1]);
  cov_flag_reset: cover property (freset && st_reg.full != '0);
endmodule : dpmfi_mailbox
`default_nettype wire

//--- common/dpmfi_pkg.sv
/*
  constants and carrier types for the two-sided mailbox block.
  assumes one clock for both sides; side index 0 is host, 1 is local.
*/
`default_nettype none
package dpmfi_pkg;
  // ****************************************
  // widths and side indices
  // ****************************************
  localparam int unsigned DW = 32;
  localparam int unsigned AW = 3;
  localparam int unsigned SIDE_HOST = 0;
  localparam int unsigned SIDE_LOCAL = 1;
  localparam int unsigned BUF_DEPTH = 2;
  // ****************************************
  // register word offsets, same map on both sides
  // ****************************************
  localparam logic [AW-1:0] ADDR_FLAGS = 3'h0;
  localparam logic [AW-1:0] ADDR_INBOUND = 3'h1;
  localparam logic [AW-1:0] ADDR_OUTBOUND = 3'h2;
  localparam logic [AW-1:0] ADDR_IRQ_CTRL = 3'h3;
  localparam logic [AW-1:0] ADDR_RESET_CTRL = 3'h4;
  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned FLAGS_L2H_LSB = 28;
  localparam int unsigned FLAGS_H2L_LSB = 12;
  localparam int unsigned CTL_EN_A = 4;
  localparam int unsigned CTL_SEL_A_LSB = 0;
  localparam int unsigned CTL_EN_B = 12;
  localparam int unsigned CTL_SEL_B_LSB = 8;
  localparam int unsigned CTL_PEND_HI = 17;
  localparam int unsigned CTL_PEND_LO = 16;
  localparam int unsigned CTL_IRQ_BIT = 23;
  localparam int unsigned RST_FLAG_BIT = 27;
  localparam logic [15:0] CTL_WMASK = 16'h1313;
  // ****************************************
  // values after reset
  // ****************************************
  localparam logic [DW-1:0] MBOX_RST = 32'h0000_0000;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [15:0] CTL_RST = 16'h0000;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic rd;
    logic wr;
    logic [AW-1:0] addr;
    logic [3:0] be;
    logic [DW-1:0] wdata;
  } dpmfi_req_t;
  typedef struct packed {
    logic en;
    logic [1:0] sel;
  } dpmfi_cond_t;
endpackage : dpmfi_pkg
`default_nettype wire

//--- logic/dpmfi_fifo.sv
/*
  small valid/ready buffer for read answers.
  assumes DEPTH of at least 2; producer honours in_ready.
*/
`default_nettype none
module dpmfi_fifo import dpmfi_pkg::*; #(
  parameter int unsigned WIDTH = DW,
  parameter int unsigned DEPTH = BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] rp;
    logic [PW-1:0] wp;
    logic [PW:0] cnt;
  } dpmfi_fifo_t;
  dpmfi_fifo_t st_reg;
  dpmfi_fifo_t st_next;
  logic push;
  logic pop;

  assign in_ready = st_reg.cnt != (PW+1)'(DEPTH);
  assign out_valid = st_reg.cnt != '0;
  assign out_data = st_reg.mem[st_reg.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wp] = in_data;
      st_next.wp = (st_reg.wp == PW'(DEPTH-1)) ? '0 : st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = (st_reg.rp == PW'(DEPTH-1)) ? '0 : st_reg.rp + 1'b1;
    end
    st_next.cnt = st_reg.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  chk_fifo_word_held: assert property (@(posedge clk) disable iff (!rstn)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("answer word changed while stalled");
  chk_fifo_full_stall: assert property (@(posedge clk) disable iff (!rstn)
    push && !pop && st_reg.cnt == (PW+1)'(DEPTH-1) |=> !in_ready)
    else $error("buffer full but still ready");
endmodule : dpmfi_fifo
`default_nettype wire

//--- logic/dpmfi_irq.sv
/*
  one side's mailbox interrupt: incoming-full and outgoing-empty requests.
  assumes events arrive as one-cycle byte masks from the mailbox core.
*/
`default_nettype none
module dpmfi_irq import dpmfi_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire dpmfi_cond_t in_cond,
  input wire dpmfi_cond_t out_cond,
  input wire logic [3:0] in_wr_ev,
  input wire logic [3:0] out_rd_ev,
  input wire logic [3:0] in_full,
  input wire logic clr_in,
  input wire logic clr_out,
  output logic pend_in,
  output logic pend_out,
  output logic irq_n
);
  typedef struct packed {
    logic pend_in;
    logic pend_out;
  } dpmfi_irq_t;
  dpmfi_irq_t st_reg;
  dpmfi_irq_t st_next;
  logic set_in;
  logic set_out;
  logic clr_in_ok;

  assign set_in = in_cond.en && in_wr_ev[in_cond.sel];
  assign set_out = out_cond.en && out_rd_ev[out_cond.sel];
  assign clr_in_ok = clr_in && !in_full[in_cond.sel];

  always_comb begin
    st_next.pend_in = set_in || (st_reg.pend_in && !clr_in_ok);
    st_next.pend_out = set_out || (st_reg.pend_out && !clr_out);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pend_in = st_reg.pend_in;
  assign pend_out = st_reg.pend_out;
  assign irq_n = !(st_reg.pend_in || st_reg.pend_out);

  chk_irq_fall_out: assert property (@(posedge clk) disable iff (!rstn)
    pend_out && !pend_in && clr_out && !set_out && !set_in |=> irq_n)
    else $error("interrupt not released after clear");
  chk_irq_in_hold: assert property (@(posedge clk) disable iff (!rstn)
    pend_in && in_full[in_cond.sel] |=> pend_in)
    else $error("incoming request cleared while byte full");
endmodule : dpmfi_irq
`default_nettype wire

//--- testbench/dpmfi_bus_master.sv
/*
  register bus master model for one side of the mailbox block.
  assumes issue and idle are called in the time step of a rising edge.
*/
`default_nettype none
module dpmfi_bus_master import dpmfi_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic stall,
  output dpmfi_req_t req,
  output logic req_valid,
  input wire logic req_ready,
  output logic rsp_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    req = '0;
    req_valid = 1'b0;
    rsp_ready = 1'b0;
  end
  // ****************************************
  // answer side, prompt or stalling
  // ****************************************
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rsp_ready <= 1'b0;
    end else begin
      rsp_ready <= !stall;
    end
  end
  // ****************************************
  // request side
  // ****************************************
  // holds the request until the edge that samples ready high
  task automatic issue(input dpmfi_req_t r);
    logic ok;
    req <= r;
    req_valid <= 1'b1;
    do begin
      @(negedge clk);
      ok = req_ready;
      @(posedge clk);
    end while (ok !== 1'b1);
  endtask : issue
  // a released request shows a changing pattern
  task automatic idle();
    req <= ~req;
    req_valid <= 1'b0;
  endtask : idle
endmodule : dpmfi_bus_master
`default_nettype wire

//--- testbench/dpmfi_mailbox_test.sv
/*
  self-checking bench for the two-sided mailbox block, with a reference model.
  assumes the package, the design and the bus master model are compiled first.
*/
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module dpmfi_mailbox_test import dpmfi_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [DW-1:0] e; logic [DW-1:0] m;} dpmfi_exp_t;
  logic clk, rstn, hold;
  wire dpmfi_req_t [1:0] req;
  wire logic [1:0] req_valid, rsp_ready;
  logic [1:0] req_ready, rsp_valid, irq_n, stall, pin, pout;
  logic [1:0][DW-1:0] rsp_data, mb;
  logic [1:0][3:0] full;
  logic [1:0][15:0] ctl;
  dpmfi_exp_t q[2][$];
  dpmfi_exp_t mon_x;
  int err_total, checks, cycles;
  dpmfi_mailbox DUT (.clk(clk), .rstn(rstn), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_data(rsp_data), .irq_n(irq_n));
  dpmfi_bus_master u_host (.clk(clk), .rstn(rstn), .stall(stall[0]), .req(req[0]),
    .req_valid(req_valid[0]), .req_ready(req_ready[0]), .rsp_ready(rsp_ready[0]));
  dpmfi_bus_master u_local (.clk(clk), .rstn(rstn), .stall(stall[1]), .req(req[1]),
    .req_valid(req_valid[1]), .req_ready(req_ready[1]), .rsp_ready(rsp_ready[1]));
  // ****************************************
  // model helpers
  // ****************************************
  function automatic logic [DW-1:0] bmask(input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      bmask[8*i +: 8] = {8{be[i]}};
    end
  endfunction : bmask
  // incoming and outgoing conditions of side t as enable and byte select
  function automatic logic [2:0] cin(input int t);
    return t ? {ctl[1][4], ctl[1][1:0]} : {ctl[0][12], ctl[0][9:8]};
  endfunction : cin
  function automatic logic [2:0] cout(input int t);
    return t ? {ctl[1][12], ctl[1][9:8]} : {ctl[0][4], ctl[0][1:0]};
  endfunction : cout
  // ****************************************
  // one access, then the model follows it
  // ****************************************
  task automatic op(input int s, input logic rd, input logic [AW-1:0] a,
                    input logic [3:0] be, input logic [DW-1:0] wd);
    dpmfi_req_t r;
    dpmfi_exp_t x;
    logic [3:0] clr;
    logic [2:0] c;
    int o;
    o = 1 - s;
    r = '{rd: rd, wr: !rd, addr: a, be: be, wdata: wd};
    x.m = bmask(be);
    if (s == 0) begin
      u_local.idle();
      u_host.issue(r);
    end else begin
      u_host.idle();
      u_local.issue(r);
    end
    if (rd) begin
      case (a)
        ADDR_FLAGS: x.e = {full[1], 12'h000, full[0], 12'h000};
        ADDR_INBOUND: begin
          x.e = mb[o];
          clr = be & full[o];
          full[o] = full[o] & ~clr;
          c = cout(o);
          if (c[2] && clr[c[1:0]]) pout[o] = 1'b1;
        end
        ADDR_OUTBOUND: x.e = mb[s];
        ADDR_IRQ_CTRL: x.e = {8'h00, pin[s] | pout[s], 5'h00,
          s ? {pout[s], pin[s]} : {pin[s], pout[s]}, ctl[s]};
        default: x.e = '0;
      endcase
      q[s].push_back(x);
    end else begin
      case (a)
        ADDR_OUTBOUND: begin
          mb[s] = (mb[s] & ~x.m) | (wd & x.m);
          full[s] = full[s] | be;
          c = cin(o);
          if (c[2] && be[c[1:0]]) pin[o] = 1'b1;
        end
        ADDR_IRQ_CTRL: begin
          c = cin(s);
          if (be[2] && wd[s ? 16 : 17] && !full[o][c[1:0]]) pin[s] = 1'b0;
          if (be[2] && wd[s ? 17 : 16]) pout[s] = 1'b0;
          if (be[0]) ctl[s][7:0] = wd[7:0] & 8'h13;
          if (be[1]) ctl[s][15:8] = wd[15:8] & 8'h13;
        end
        ADDR_RESET_CTRL: if (be[3] && wd[27]) full = '0;
        default: ;
      endcase
    end
  endtask : op
  task automatic test_done();
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  // ****************************************
  // watchers, stall pattern and time limit
  // ****************************************
  always @(posedge clk) begin
    if (rstn) begin
      for (int s = 0; s < 2; s++) begin
        if (rsp_valid[s] === 1'b1 && rsp_ready[s]) begin
          if (q[s].size() == 0) begin
            `CHK("rsp_extra", 1'b0, 1'b1)
          end else begin
            mon_x = q[s].pop_front();
            `CHK("rsp_data", mon_x.e & mon_x.m, rsp_data[s] & mon_x.m)
          end
        end
      end
    end
  end
  always @(negedge clk) begin
    if (rstn) begin
      `CHK("irq_n", ~(pin | pout), irq_n)
    end
  end
  always @(posedge clk) begin
    stall <= hold ? 2'b11 : {$urandom % 3 == 0, $urandom % 3 == 0};
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h733C84BE));
    rstn = 1'b0;
    hold = 1'b0;
    stall = 2'b00;
    mb = '0;
    full = '0;
    ctl = '0;
    pin = '0;
    pout = '0;
    err_total = 0;
    checks = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // values after reset, unmapped places included
    for (int s = 0; s < 2; s++) begin
      for (int a = 0; a < 8; a++) begin
        op(s, 1'b1, a[AW-1:0], 4'hF, '0);
      end
    end
    // the last reader lets go, or its read would be taken again every cycle
    u_local.idle();
    // answer buffer fills while the receiver stalls
    while (q[0].size() != 0) @(posedge clk);
    hold <= 1'b1;
    repeat (3) @(posedge clk);
    op(0, 1'b1, ADDR_OUTBOUND, 4'hF, '0);
    op(0, 1'b1, ADDR_FLAGS, 4'hF, '0);
    u_host.idle();
    @(negedge clk);
    `CHK("req_ready", 1'b0, req_ready[0])
    @(posedge clk);
    hold <= 1'b0;
    // random traffic on both sides
    for (int i = 0; i < 800; i++) begin
      op($urandom % 2, 1'($urandom % 2), AW'($urandom % 8),
         ($urandom % 2) ? 4'hF : 4'($urandom), $urandom);
    end
    u_host.idle();
    u_local.idle();
    repeat (20) @(posedge clk);
    `CHK("rsp_left", 0, q[0].size() + q[1].size())
    test_done();
  end
endmodule : dpmfi_mailbox_test
`default_nettype wire
